/* bench/asa_adapter_assertions.sv */
module asa_adapter_assertions #(
    parameter logic [7:0] ADDR_CODE = 8'h1B
) (
    input wire logic mclk,
    input wire logic rst,
    input wire asa_pkg::asa_cmd_s cmd,
    input wire logic [7:0] rd_data,
    input wire logic irq,
    input wire asa_pkg::asa_modem_in_s modem_in,
    input wire asa_pkg::asa_modem_out_s modem_out,
    input wire logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sel_ff;
    logic data_mode_ff;
    logic ring_ff;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ========================================
    // shadow of selection, input mode and ring mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_ff <= 1'b0;
        end else if (cmd.sel) begin
            sel_ff <= (cmd.data == ADDR_CODE);
        end
    end
    always_ff @(posedge mclk) begin
        if (rst || (sel_ff && cmd.stop)) begin
            data_mode_ff <= 1'b0;
        end else if (sel_ff && cmd.wr_mode) begin
            data_mode_ff <= cmd.data[asa_pkg::IM_DATA];
        end
    end
    always_ff @(posedge mclk) begin
        if (rst || (sel_ff && cmd.stop)) begin
            ring_ff <= 1'b0;
        end else if (sel_ff && cmd.wr_aux) begin
            ring_ff <= cmd.data[asa_pkg::AX_RING];
        end
    end
    // ========================================
    // sequences and properties
    sequence s_ring_enter;
        sel_ff && cmd.wr_aux && cmd.data[asa_pkg::AX_RING] && !ring_ff;
    endsequence
    sequence s_ri_quiet;
        !modem_in.ri [*2];
    endsequence
    property p_modem_write;
        sel_ff && cmd.wr_modem |=> modem_out == $past(cmd.data[2:0]);
    endproperty
    a_modem_write: assert property (p_modem_write)
        else $error("modem outputs differ from written byte");
    property p_unsel;
        !sel_ff && !cmd.sel && (cmd.wr_modem || cmd.stop)
            |=> $stable(modem_out);
    endproperty
    a_unsel: assert property (p_unsel)
        else $error("command taken while not selected");
    property p_stop;
        sel_ff && cmd.stop |=> modem_out == '0 ##1 !irq;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop left outputs or request set");
    property p_break;
        sel_ff && cmd.wr_modem && cmd.data[asa_pkg::MC_BREAK]
            |-> ##[1:2] !txd;
    endproperty
    a_break: assert property (p_break)
        else $error("break did not hold line at space");
    property p_rd_stable;
        !(sel_ff && cmd.rd) |=> $stable(rd_data);
    endproperty
    a_rd_stable: assert property (p_rd_stable)
        else $error("read data changed without a read");
    property p_status_modem;
        sel_ff && cmd.rd && !data_mode_ff |=> rd_data[4:0] == $past(modem_in);
    endproperty
    a_status_modem: assert property (p_status_modem)
        else $error("status low bits differ from modem inputs");
    property p_ring_enter;
        s_ring_enter ##1 s_ri_quiet |=> !irq;
    endproperty
    a_ring_enter: assert property (p_ring_enter)
        else $error("request raised in ring mode without ring");
    property p_ring_latch;
        ring_ff && $past(ring_ff) && modem_in.ri |-> ##[1:2] irq;
    endproperty
    a_ring_latch: assert property (p_ring_latch)
        else $error("ring did not raise the request");
    property p_ring_hold;
        ring_ff && $past(ring_ff) && irq
            && !(sel_ff && (cmd.stop || cmd.wr_aux)) |=> irq;
    endproperty
    a_ring_hold: assert property (p_ring_hold)
        else $error("ring request dropped inside ring mode");
endmodule

bind asa_adapter asa_adapter_assertions #(.ADDR_CODE(ADDR_CODE))
    asa_adapter_assertions_inst (.mclk(mclk), .rst(rst), .cmd(cmd),
    .rd_data(rd_data), .irq(irq), .modem_in(modem_in),
    .modem_out(modem_out), .rxd(rxd), .txd(txd));

/* bench/asa_modem_model.sv */
module asa_modem_model #(
    parameter int BIT_CLKS = 2083
) (
    input wire logic mclk,
    input wire asa_pkg::asa_fmt_s fmt,
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cap_byte;
    logic cap_ok;
    int cap_cnt;
    initial begin
        rxd = 1'b1;
        cap_byte = '0;
        cap_ok = 1'b0;
        cap_cnt = 0;
    end
    // ========================================
    // sends one frame on the receive line, parity optionally wrong
    task automatic send(input logic [7:0] b, input logic bad);
        logic p;
        p = ~fmt.even ^ bad;
        @(negedge mclk);
        rxd = 1'b0;
        repeat (BIT_CLKS) @(negedge mclk);
        for (int i = 0; i < fmt.nbits; i++) begin
            rxd = b[i];
            p = p ^ b[i];
            repeat (BIT_CLKS) @(negedge mclk);
        end
        if (fmt.parity_on) begin
            rxd = p;
            repeat (BIT_CLKS) @(negedge mclk);
        end
        rxd = 1'b1;
        repeat ((1 + fmt.two_stop) * BIT_CLKS) @(negedge mclk);
    endtask
    // ========================================
    // decodes frames from the transmit line at mid bit
    always begin : rx_frame
        logic x;
        logic ok;
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge mclk);
        if (txd === 1'b0) begin
            x = ~fmt.even;
            ok = 1'b1;
            cap_byte = '0;
            for (int i = 0; i < fmt.nbits; i++) begin
                repeat (BIT_CLKS) @(posedge mclk);
                cap_byte[i] = txd;
                x = x ^ txd;
            end
            if (fmt.parity_on) begin
                repeat (BIT_CLKS) @(posedge mclk);
                ok = !(x ^ txd);
            end
            for (int i = 0; i <= fmt.two_stop; i++) begin
                repeat (BIT_CLKS) @(posedge mclk);
                ok = ok & (txd === 1'b1);
            end
            cap_ok = ok;
            cap_cnt++;
        end
    end
endmodule

/* bench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADDR = 8'h4B;
    // rs-232 link, so rates above 9600 are allowed
    localparam int BIT_CLKS = asa_pkg::CLK_HZ / 19200;
    logic mclk, rst, irq, rxd, txd;
    logic [7:0] rd_data, v;
    asa_pkg::asa_cmd_s cmd;
    asa_pkg::asa_modem_in_s modem_in;
    asa_pkg::asa_modem_out_s modem_out;
    asa_pkg::asa_fmt_s fmt;
    int n_mismatch, n_checks;
    asa_adapter #(.ADDR_CODE(ADDR)) asa_adapter_inst (.mclk(mclk),
        .rst(rst), .cmd(cmd), .rd_data(rd_data), .irq(irq),
        .modem_in(modem_in), .modem_out(modem_out), .rxd(rxd), .txd(txd));
    asa_modem_model #(.BIT_CLKS(BIT_CLKS)) asa_modem_model_inst (
        .mclk(mclk), .fmt(fmt), .txd(txd), .rxd(rxd));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ========================================
    // shared tasks
    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // strobe k: 0 sel 1 stop 2 rd 3 data 4 modem 5 line 6 mode 7 aux
    task automatic issue(input int k, input logic [7:0] d);
        @(negedge mclk);
        cmd = asa_pkg::asa_cmd_s'({8'(8'h80 >> k), d});
        @(negedge mclk);
        cmd = '0;
    endtask
    task automatic rd(output logic [7:0] r);
        issue(2, 8'h00);
        @(negedge mclk);
        r = rd_data;
    endtask
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask
    task automatic wait_cap(input int old);
        int n;
        n = 0;
        while (asa_modem_model_inst.cap_cnt == old && n < 40000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 40000) begin
            n_mismatch++;
            close_out();
        end
    endtask
    // ========================================
    // scenarios
    task automatic t_select();
        chk({6'h00, txd, irq}, 8'h02);
        issue(0, 8'h2B);
        issue(4, 8'h07);
        rd(v);
        chk(v, 8'h00);
        chk({5'h00, modem_out}, 8'h00);
        issue(0, ADDR);
    endtask
    task automatic t_modem();
        issue(4, 8'h07);
        settle();
        chk({5'h00, modem_out}, 8'h07);
        issue(4, 8'h08);
        settle();
        chk({4'h0, txd, modem_out}, 8'h00);
        issue(4, 8'h00);
        settle();
        chk({7'h00, txd}, 8'h01);
        repeat (BIT_CLKS) @(negedge mclk);
    endtask
    task automatic t_status();
        modem_in = 5'h15;
        settle();
        rd(v);
        chk(v, 8'h55);
        modem_in = 5'h0A;
        rd(v);
        chk(v, 8'h4A);
    endtask
    task automatic t_frame();
        int c;
        c = asa_modem_model_inst.cap_cnt;
        issue(5, 8'h1F);
        fork
            asa_modem_model_inst.send(8'h33, 1'b0);
            begin
                issue(3, 8'h5A);
                settle();
                rd(v);
                chk(v & 8'h40, 8'h00);
            end
        join
        wait_cap(c);
        chk(asa_modem_model_inst.cap_byte, 8'h5A);
        chk({7'h00, asa_modem_model_inst.cap_ok}, 8'h01);
        repeat (BIT_CLKS) @(negedge mclk);
        rd(v);
        chk(v, 8'hCA);
        chk({7'h00, irq}, 8'h01);
        issue(6, 8'h01);
        rd(v);
        chk(v & 8'h7F, 8'h33);
        issue(6, 8'h00);
        rd(v);
        chk(v, 8'h4A);
        settle();
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_error();
        int c;
        c = asa_modem_model_inst.cap_cnt;
        issue(5, 8'h9F);
        issue(7, 8'h8F);
        fmt.nbits = 4'h5;
        fmt.two_stop = 1'b1;
        fork
            asa_modem_model_inst.send(8'h15, 1'b1);
            issue(3, 8'h35);
        join
        wait_cap(c);
        chk(asa_modem_model_inst.cap_byte, 8'h15);
        chk({7'h00, asa_modem_model_inst.cap_ok}, 8'h01);
        repeat (BIT_CLKS) @(negedge mclk);
        rd(v);
        chk(v, 8'hEA);
        issue(4, 8'h07);
        issue(6, 8'h01);
        issue(1, 8'h00);
        settle();
        chk({5'h00, modem_out}, 8'h00);
        rd(v);
        chk(v, 8'h4A);
    endtask
    task automatic t_irq();
        issue(7, 8'h2F);
        settle();
        chk({7'h00, irq}, 8'h01);
        issue(7, 8'h6F);
        settle();
        chk({7'h00, irq}, 8'h00);
        modem_in = 5'h0B;
        settle();
        modem_in = 5'h0A;
        settle();
        chk({7'h00, irq}, 8'h01);
        issue(7, 8'h0F);
        settle();
        chk({7'h00, irq}, 8'h00);
        issue(0, 8'h2B);
        issue(4, 8'h07);
        settle();
        chk({5'h00, modem_out}, 8'h00);
    endtask
    // ========================================
    // main sequence
    initial begin
        rst = 1'b1;
        cmd = '0;
        modem_in = '0;
        fmt = '{1'b0, 1'b1, 1'b1, 4'h7};
        n_mismatch = 0;
        n_checks = 0;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        t_select();
        t_modem();
        t_status();
        t_frame();
        t_error();
        t_irq();
        close_out();
    end
endmodule

/* logic/asa_adapter.sv */
module asa_adapter #(
    parameter logic [7:0] ADDR_CODE = 8'h1B
) (
    input wire logic mclk,
    input wire logic rst,
    input wire asa_pkg::asa_cmd_s cmd,
    output logic [7:0] rd_data,
    output logic irq,
    input wire asa_pkg::asa_modem_in_s modem_in,
    output asa_pkg::asa_modem_out_s modem_out,
    input wire logic rxd,
    output logic txd
);
    // elaboration check: only the four switch codes exist
    if (ADDR_CODE != 8'h1B && ADDR_CODE != 8'h2B &&
        ADDR_CODE != 8'h4B && ADDR_CODE != 8'h8B) begin : g_bad_addr
        $error("ADDR_CODE must be 1B, 2B, 4B or 8B");
    end

    typedef enum logic [1:0] {ASA_IDLE, ASA_START, ASA_BITS, ASA_STOP}
        asa_state_e;

    logic sel_ff;
    logic act;
    logic [7:0] line_ff;
    logic [3:0] rx_rate_ff;
    logic data_mode_ff;
    logic low_ff;
    logic ring_ff;
    logic txirq_ff;
    logic [3:0] mctl_ff;
    logic ring_irq_ff;
    logic rx_avail_ff;
    logic err_ff;
    logic tx_need_ff;
    logic [7:0] rx_buf_ff;
    logic [7:0] status;
    asa_pkg::asa_fmt_s fmt;
    logic tx_tick;
    logic rx_tick;

    // ========================================
    // selection and command gating
    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_ff <= 1'b0;
        end else if (cmd.sel) begin
            sel_ff <= (cmd.data == ADDR_CODE);
        end
    end
    assign act = sel_ff;

    // line parameters, both rates equal on line write
    always_ff @(posedge mclk) begin
        if (rst) begin
            line_ff <= asa_pkg::LP_RESET;
            rx_rate_ff <= asa_pkg::RATE_RESET;
        end else if (act && cmd.wr_line) begin
            line_ff <= cmd.data;
            rx_rate_ff <= cmd.data[3:0];
        end else if (act && cmd.wr_aux) begin
            rx_rate_ff <= cmd.data[3:0];
        end
    end

    // input selector mode
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            data_mode_ff <= 1'b0;
        end else if (act && cmd.wr_mode) begin
            data_mode_ff <= cmd.data[asa_pkg::IM_DATA];
        end
    end

    // auxiliary modes
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            low_ff <= 1'b0;
            ring_ff <= 1'b0;
            txirq_ff <= 1'b0;
        end else if (act && cmd.wr_aux) begin
            low_ff <= cmd.data[asa_pkg::AX_LOW_BITS];
            ring_ff <= cmd.data[asa_pkg::AX_RING];
            txirq_ff <= cmd.data[asa_pkg::AX_TX_IRQ];
        end
    end

    // modem control outputs
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            mctl_ff <= 4'h0;
        end else if (act && cmd.wr_modem) begin
            mctl_ff <= cmd.data[3:0];
        end
    end
    assign modem_out.stx = mctl_ff[asa_pkg::MC_STX];
    assign modem_out.dtr = mctl_ff[asa_pkg::MC_DTR];
    assign modem_out.rts = mctl_ff[asa_pkg::MC_RTS];

    // character format from line byte and low bit mode
    always_comb begin
        fmt.two_stop = line_ff[asa_pkg::LP_TWO_STOP];
        fmt.parity_on = ~line_ff[asa_pkg::LP_NO_PARITY];
        fmt.even = line_ff[asa_pkg::LP_EVEN];
        fmt.nbits = 4'(4'h5 + (low_ff ? 4'h0 : 4'h2)
            + {3'h0, line_ff[asa_pkg::LP_LONG_CHAR]});
    end

    // ========================================
    // rate dividers
    asa_rate_gen u_tx_rate (
        .mclk(mclk),
        .rst(rst),
        .code(line_ff[3:0]),
        .tick(tx_tick)
    );
    asa_rate_gen u_rx_rate (
        .mclk(mclk),
        .rst(rst),
        .code(rx_rate_ff),
        .tick(rx_tick)
    );

    // ========================================
    // transmitter
    asa_state_e tx_st_ff;
    logic [3:0] tx_sub_ff;
    logic [3:0] tx_idx_ff;
    logic [7:0] tx_hold_ff;
    logic tx_pend_ff;
    logic tx_bit_ff;
    logic tx_par_ff;
    logic tx_load;
    logic tx_done;

    assign tx_load = act && cmd.wr_data;

    // needed flag: a fresh load wins over frame end
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            tx_need_ff <= 1'b1;
        end else if (tx_load) begin
            tx_need_ff <= 1'b0;
        end else if (tx_done) begin
            tx_need_ff <= 1'b1;
        end
    end

    // hold register for the byte waiting to be sent
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            tx_pend_ff <= 1'b0;
            tx_hold_ff <= 8'h00;
        end else if (tx_load) begin
            tx_pend_ff <= 1'b1;
            tx_hold_ff <= cmd.data;
        end else if (tx_st_ff == ASA_IDLE && tx_tick && tx_pend_ff) begin
            tx_pend_ff <= 1'b0;
        end
    end

    // frame sequencer, one bit per sixteen ticks
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            tx_st_ff <= ASA_IDLE;
            tx_sub_ff <= 4'h0;
            tx_idx_ff <= 4'h0;
            tx_bit_ff <= 1'b1;
            tx_par_ff <= 1'b0;
        end else if (tx_tick) begin
            tx_sub_ff <= tx_sub_ff + 4'h1;
            case (tx_st_ff)
                ASA_IDLE: begin
                    tx_bit_ff <= 1'b1;
                    tx_sub_ff <= 4'h0;
                    if (tx_pend_ff) begin
                        tx_st_ff <= ASA_START;
                        tx_bit_ff <= 1'b0;
                        tx_idx_ff <= 4'h0;
                        tx_par_ff <= ~fmt.even;
                    end
                end
                ASA_START: begin
                    if (tx_sub_ff == 4'hF) begin
                        tx_st_ff <= ASA_BITS;
                        tx_bit_ff <= tx_hold_ff[0];
                        tx_par_ff <= tx_par_ff ^ tx_hold_ff[0];
                        tx_idx_ff <= 4'h1;
                    end
                end
                ASA_BITS: begin
                    if (tx_sub_ff == 4'hF) begin
                        tx_idx_ff <= tx_idx_ff + 4'h1;
                        if (tx_idx_ff < fmt.nbits) begin
                            tx_bit_ff <= tx_hold_ff[tx_idx_ff[2:0]];
                            tx_par_ff <= tx_par_ff
                                ^ tx_hold_ff[tx_idx_ff[2:0]];
                        end else if (tx_idx_ff == fmt.nbits
                                     && fmt.parity_on) begin
                            tx_bit_ff <= tx_par_ff;
                        end else begin
                            tx_st_ff <= ASA_STOP;
                            tx_bit_ff <= 1'b1;
                            tx_idx_ff <= 4'h0;
                        end
                    end
                end
                ASA_STOP: begin
                    if (tx_sub_ff == 4'hF) begin
                        tx_idx_ff <= tx_idx_ff + 4'h1;
                        if (tx_idx_ff != 4'h0 || !fmt.two_stop) begin
                            tx_st_ff <= ASA_IDLE;
                        end
                    end
                end
                default: tx_st_ff <= ASA_IDLE;
            endcase
        end
    end
    assign tx_done = tx_tick && tx_st_ff == ASA_STOP && tx_sub_ff == 4'hF
        && (tx_idx_ff != 4'h0 || !fmt.two_stop) && !tx_pend_ff;
    assign txd = tx_bit_ff & ~mctl_ff[asa_pkg::MC_BREAK];

    // ========================================
    // receiver, samples at mid bit
    asa_state_e rx_st_ff;
    logic [3:0] rx_sub_ff;
    logic [3:0] rx_idx_ff;
    logic [7:0] rx_sh_ff;
    logic rx_par_ff;
    logic rx_perr_ff;
    logic rx_mid;
    logic rx_done;
    logic rx_frame_ok;
    logic rd_data_cmd;

    assign rx_mid = rx_tick && rx_sub_ff == 4'h7;
    assign rx_done = rx_mid && rx_st_ff == ASA_STOP;
    assign rx_frame_ok = rxd;
    assign rd_data_cmd = act && cmd.rd && data_mode_ff;

    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            rx_st_ff <= ASA_IDLE;
            rx_sub_ff <= 4'h0;
            rx_idx_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            rx_par_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
        end else if (rx_tick) begin
            rx_sub_ff <= rx_sub_ff + 4'h1;
            case (rx_st_ff)
                ASA_IDLE: begin
                    rx_sub_ff <= 4'h0;
                    if (!rxd) begin
                        rx_st_ff <= ASA_START;
                        rx_sub_ff <= 4'h1;
                    end
                end
                ASA_START: begin
                    if (rx_sub_ff == 4'h7) begin
                        rx_st_ff <= rxd ? ASA_IDLE : ASA_BITS;
                        rx_idx_ff <= 4'h0;
                        rx_sh_ff <= 8'h00;
                        rx_par_ff <= ~fmt.even;
                        rx_perr_ff <= 1'b0;
                    end
                end
                ASA_BITS: begin
                    if (rx_sub_ff == 4'h7) begin
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                        if (rx_idx_ff < fmt.nbits) begin
                            rx_sh_ff[rx_idx_ff[2:0]] <= rxd;
                            rx_par_ff <= rx_par_ff ^ rxd;
                            if (rx_idx_ff + 4'h1 == fmt.nbits
                                && !fmt.parity_on) begin
                                rx_st_ff <= ASA_STOP;
                            end
                        end else begin
                            rx_perr_ff <= (rx_par_ff != rxd);
                            rx_st_ff <= ASA_STOP;
                        end
                    end
                end
                ASA_STOP: begin
                    if (rx_sub_ff == 4'h7) begin
                        rx_st_ff <= ASA_IDLE;
                    end
                end
                default: rx_st_ff <= ASA_IDLE;
            endcase
        end
    end

    // received flag, error flag and buffer; arrival wins over read
    always_ff @(posedge mclk) begin
        if (rst || (act && cmd.stop)) begin
            rx_avail_ff <= 1'b0;
            err_ff <= 1'b0;
            rx_buf_ff <= 8'h00;
        end else if (rx_done) begin
            rx_avail_ff <= 1'b1;
            rx_buf_ff <= rx_sh_ff;
            err_ff <= rx_perr_ff | ~rx_frame_ok | rx_avail_ff;
        end else if (rd_data_cmd) begin
            rx_avail_ff <= 1'b0;
        end
    end

    // ========================================
    // status byte and shared input port
    assign status = {rx_avail_ff, tx_need_ff, err_ff, modem_in.cts,
        modem_in.srx, modem_in.dcd, modem_in.dsr, modem_in.ri};

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (act && cmd.rd) begin
            rd_data <= data_mode_ff ? rx_buf_ff : status;
        end
    end

    // ring interrupt latch, cleared when ring mode ends
    always_ff @(posedge mclk) begin
        if (rst || !ring_ff) begin
            ring_irq_ff <= 1'b0;
        end else if (modem_in.ri) begin
            ring_irq_ff <= 1'b1;
        end
    end

    // single combined request
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (ring_ff) begin
            irq <= ring_irq_ff;
        end else begin
            irq <= rx_avail_ff | (txirq_ff & tx_need_ff);
        end
    end
endmodule

/* logic/asa_pkg.sv */
package asa_pkg;
    // ========================================
    // status byte fields
    localparam int ST_RX_AVAIL = 7;
    localparam int ST_TX_NEED = 6;
    localparam int ST_ERROR = 5;
    // modem control fields
    localparam int MC_BREAK = 3;
    localparam int MC_STX = 2;
    localparam int MC_DTR = 1;
    localparam int MC_RTS = 0;
    // line parameter fields
    localparam int LP_TWO_STOP = 7;
    localparam int LP_LONG_CHAR = 6;
    localparam int LP_NO_PARITY = 5;
    localparam int LP_EVEN = 4;
    // auxiliary and input mode fields
    localparam int AX_LOW_BITS = 7;
    localparam int AX_RING = 6;
    localparam int AX_TX_IRQ = 5;
    localparam int IM_DATA = 0;
    // reset values
    localparam logic [7:0] LP_RESET = 8'hEE;
    localparam logic [3:0] RATE_RESET = 4'hE;
    // clock and oversampling
    localparam int CLK_HZ = 40000000;
    localparam int OVERSAMPLE = 16;

    // ========================================
    // one command from the cpu i/o bus
    typedef struct packed {
        logic sel;
        logic stop;
        logic rd;
        logic wr_data;
        logic wr_modem;
        logic wr_line;
        logic wr_mode;
        logic wr_aux;
        logic [7:0] data;
    } asa_cmd_s;

    // modem inputs
    typedef struct packed {
        logic cts;
        logic srx;
        logic dcd;
        logic dsr;
        logic ri;
    } asa_modem_in_s;

    // modem outputs
    typedef struct packed {
        logic stx;
        logic dtr;
        logic rts;
    } asa_modem_out_s;

    // character format
    typedef struct packed {
        logic two_stop;
        logic parity_on;
        logic even;
        logic [3:0] nbits;
    } asa_fmt_s;

    // ========================================
    // rate code to x16 tick divisor (baud rate times ten avoids 134.5)
    function automatic logic [15:0] asa_divisor(input logic [3:0] code);
        int unsigned baud10;
        baud10 = 500;
        case (code)
            4'h0: baud10 = 500;
            4'h1: baud10 = 750;
            4'h2: baud10 = 1100;
            4'h3: baud10 = 1345;
            4'h4: baud10 = 1500;
            4'h5: baud10 = 3000;
            4'h6: baud10 = 6000;
            4'h7: baud10 = 12000;
            4'h8: baud10 = 18000;
            4'h9: baud10 = 20000;
            4'hA: baud10 = 24000;
            4'hB: baud10 = 36000;
            4'hC: baud10 = 48000;
            4'hD: baud10 = 72000;
            4'hE: baud10 = 96000;
            default: baud10 = 192000;
        endcase
        return 16'((64'(CLK_HZ) * 10) / (64'(baud10) * OVERSAMPLE));
    endfunction
endpackage

/* logic/asa_rate_gen.sv */
// x16 oversampling tick divider for one rate code
module asa_rate_gen (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] code,
    output logic tick
);
    logic [15:0] cnt_ff;
    logic [15:0] div;

    // ========================================
    // divisor lookup
    assign div = asa_pkg::asa_divisor(code);

    // count down and pulse once per period
    always_ff @(posedge mclk) begin
        if (rst || cnt_ff == 16'h0000) begin
            cnt_ff <= div - 16'h0001;
        end else begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    // one-cycle enable pulse
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_ff == 16'h0000);
        end
    end
endmodule
